// file: crlc_pkg.sv
// Package of register map, field layout and reset values for the ladder block
package crlc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_LADDER_CTRL = 12'h000;
  localparam logic [11:0] OFS_CMP_CTRL = 12'h004;
  localparam logic [11:0] OFS_PORTF_DIR = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam int unsigned BIT_PWR_EN = 7;
  localparam int unsigned BIT_PIN_OE = 6;
  localparam int unsigned BIT_RANGE = 5;
  localparam int unsigned BIT_SOURCE = 4;
  localparam int unsigned TAP_MSB = 3;
  localparam int unsigned TAP_LSB = 0;
  localparam int unsigned CMP_OUT_MSB = 7;
  localparam int unsigned CMP_OUT_LSB = 6;
  localparam int unsigned CMP_MODE_MSB = 2;
  localparam int unsigned CMP_MODE_LSB = 0;
  localparam int unsigned PIN_DIR_BIT = 5;
  localparam logic [7:0] RST_LADDER_CTRL = 8'h00;
  localparam logic [7:0] RST_CMP_CTRL = 8'h00;
  localparam logic [7:0] RST_PORTF_DIR = 8'hFF;
  localparam logic [7:0] CMP_CTRL_WMASK = 8'h3F;
endpackage : crlc_pkg

// file: crlc_reg8.sv
// Eight-bit software register with write mask and reset value
`timescale 1ns/1ps
module crlc_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] q_out
);
  logic [7:0] q_reg;
  logic [7:0] q_next;
  always_comb begin
    q_next = (q_reg & ~WMASK) | (wdata_in & WMASK);
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      q_reg <= RESET_VAL;
    end else if (wr_in) begin
      q_reg <= q_next;
    end
  end
  assign q_out = q_reg;
endmodule : crlc_reg8

// file: crlc_top.sv
// Comparator reference ladder control register bank with APB slave
`timescale 1ns/1ps
module crlc_top (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [1:0] comparator_result_in,
  input wire logic sleep_in,
  output logic ladder_power_enable_out,
  output logic ladder_pin_output_enable_out,
  output logic ladder_range_select_out,
  output logic ladder_source_select_out,
  output logic [3:0] ladder_tap_code_out,
  output logic shared_analog_pin_connect_out,
  output logic [2:0] comparator_mode_field_out,
  output logic [7:0] port_f_direction_out
);
  logic access_w;
  logic wr_en;
  logic hit_ladder;
  logic hit_cmp;
  logic hit_dir;
  logic hit_stat;
  logic mapped;
  logic [7:0] ladder_q;
  logic [7:0] cmp_q;
  logic [7:0] dir_q;
  logic [7:0] cmp_view;
  logic [1:0] cmp_sync1_reg;
  logic [1:0] cmp_sync2_reg;
  logic [1:0] cmp_sync3_reg;
  logic [1:0] cmp_stable_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rdata_next;

  assign access_w = psel_in && penable_in;
  assign hit_ladder = paddr_in == crlc_pkg::OFS_LADDER_CTRL;
  assign hit_cmp = paddr_in == crlc_pkg::OFS_CMP_CTRL;
  assign hit_dir = paddr_in == crlc_pkg::OFS_PORTF_DIR;
  assign hit_stat = paddr_in == crlc_pkg::OFS_STATUS;
  assign mapped = hit_ladder || hit_cmp || hit_dir || hit_stat;
  // Only byte lane 0 carries register data
  assign wr_en = access_w && pwrite_in && pstrb_in[0];

  // Zero wait states; unmapped address answers with an error
  assign pready_out = 1'b1;
  assign pslverr_out = access_w && !mapped;

  // Sleep has no reset path, contents survive wake-up
  crlc_reg8 #(
    .RESET_VAL(crlc_pkg::RST_LADDER_CTRL),
    .WMASK(8'hFF)
  ) u_ladder (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .wr_in(wr_en && hit_ladder),
    .wdata_in(pwdata_in[7:0]),
    .q_out(ladder_q)
  );

  // Output bits are read only
  crlc_reg8 #(
    .RESET_VAL(crlc_pkg::RST_CMP_CTRL),
    .WMASK(crlc_pkg::CMP_CTRL_WMASK)
  ) u_cmp (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .wr_in(wr_en && hit_cmp),
    .wdata_in(pwdata_in[7:0]),
    .q_out(cmp_q)
  );

  crlc_reg8 #(
    .RESET_VAL(crlc_pkg::RST_PORTF_DIR),
    .WMASK(8'hFF)
  ) u_dir (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .wr_in(wr_en && hit_dir),
    .wdata_in(pwdata_in[7:0]),
    .q_out(dir_q)
  );

  // Comparator results come from analog, three-stage synchroniser
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cmp_sync1_reg <= 2'h0;
      cmp_sync2_reg <= 2'h0;
      cmp_sync3_reg <= 2'h0;
    end else begin
      cmp_sync1_reg <= comparator_result_in;
      cmp_sync2_reg <= cmp_sync1_reg;
      cmp_sync3_reg <= cmp_sync2_reg;
    end
  end

  // Accept a bit once the last two stages agree
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cmp_stable_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cmp_sync2_reg[i] == cmp_sync3_reg[i]) begin
          cmp_stable_reg[i] <= cmp_sync3_reg[i];
        end
      end
    end
  end

  always_comb begin
    cmp_view = cmp_q;
    cmp_view[crlc_pkg::CMP_OUT_MSB:crlc_pkg::CMP_OUT_LSB] = cmp_stable_reg;
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_ladder) begin
      rdata_next[7:0] = ladder_q;
    end else if (hit_cmp) begin
      rdata_next[7:0] = cmp_view;
    end else if (hit_dir) begin
      rdata_next[7:0] = dir_q;
    end else if (hit_stat) begin
      rdata_next[0] = shared_analog_pin_connect_out;
      rdata_next[1] = sleep_in;
    end
  end

  // Read data registered from the setup phase
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_reg <= rdata_next;
    end
  end
  assign prdata_out = prdata_reg;

  // Control fields straight from the register flops
  assign ladder_power_enable_out = ladder_q[crlc_pkg::BIT_PWR_EN];
  assign ladder_pin_output_enable_out =
    ladder_q[crlc_pkg::BIT_PIN_OE];
  assign ladder_range_select_out = ladder_q[crlc_pkg::BIT_RANGE];
  assign ladder_source_select_out = ladder_q[crlc_pkg::BIT_SOURCE];
  // Full 4-bit code passed, sixteen levels per range
  assign ladder_tap_code_out =
    ladder_q[crlc_pkg::TAP_MSB:crlc_pkg::TAP_LSB];
  assign shared_analog_pin_connect_out = ladder_q[crlc_pkg::BIT_PIN_OE] &&
    dir_q[crlc_pkg::PIN_DIR_BIT];
  assign comparator_mode_field_out =
    cmp_q[crlc_pkg::CMP_MODE_MSB:crlc_pkg::CMP_MODE_LSB];
  assign port_f_direction_out = dir_q;

  property p_reset_clear;
    @(posedge ref_clk_in)
    !rstn_in |=> ladder_q == 8'h00 && comparator_mode_field_out == 3'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("control not cleared by reset");

  property p_write_update;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (wr_en && hit_ladder) |=> ladder_q == $past(pwdata_in[7:0]);
  endproperty
  a_write_update: assert property (p_write_update)
    else $error("ladder control missed write");

  property p_hold;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !(wr_en && hit_ladder) |=> $stable(ladder_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("ladder control changed without write");

  property p_power;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (wr_en && hit_ladder) |=> ladder_power_enable_out == $past(pwdata_in[7]);
  endproperty
  a_power: assert property (p_power)
    else $error("power enable wrong");

  property p_pin_oe;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (wr_en && hit_ladder) |=>
      ladder_pin_output_enable_out == $past(pwdata_in[6]);
  endproperty
  a_pin_oe: assert property (p_pin_oe)
    else $error("pin output enable wrong");

  property p_range_src;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (wr_en && hit_ladder) |=> ladder_range_select_out == $past(pwdata_in[5])
      && ladder_source_select_out == $past(pwdata_in[4]);
  endproperty
  a_range_src: assert property (p_range_src)
    else $error("range or source select wrong");

  property p_tap;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (wr_en && hit_ladder) |=> ladder_tap_code_out == $past(pwdata_in[3:0]);
  endproperty
  a_tap: assert property (p_tap)
    else $error("tap code wrong");

  property p_pin_connect;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    shared_analog_pin_connect_out |->
      ladder_pin_output_enable_out && port_f_direction_out[5];
  endproperty
  a_pin_connect: assert property (p_pin_connect)
    else $error("pin connected without both enables");

  property p_readback;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (psel_in && !penable_in && !pwrite_in && hit_ladder) |=>
      prdata_out == {24'h000000, $past(ladder_q)};
  endproperty
  a_readback: assert property (p_readback)
    else $error("ladder readback wrong");

  property p_independent;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (wr_en && hit_cmp) |=> $stable(ladder_q);
  endproperty
  a_independent: assert property (p_independent)
    else $error("comparator write disturbed ladder");

  property p_mode_reset;
    @(posedge ref_clk_in)
    !rstn_in |=> comparator_mode_field_out == 3'h0;
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("comparator mode not reset");

  property p_reset_outputs;
    @(posedge ref_clk_in)
    !rstn_in |=> !ladder_power_enable_out && !ladder_pin_output_enable_out
      && !ladder_range_select_out && !ladder_source_select_out
      && ladder_tap_code_out == 4'h0 && !shared_analog_pin_connect_out;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("ladder outputs not cleared by reset");

  // Writes without lane 0 must leave every register alone
  property p_mask_ignored;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (access_w && pwrite_in && !pstrb_in[0]) |=>
      $stable(ladder_q) && $stable(dir_q) && $stable(cmp_q);
  endproperty
  a_mask_ignored: assert property (p_mask_ignored)
    else $error("write without lane 0 changed a register");

  property p_unmapped_ignored;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (access_w && pwrite_in && !mapped) |=>
      $stable(ladder_q) && $stable(dir_q) && $stable(cmp_q);
  endproperty
  a_unmapped_ignored: assert property (p_unmapped_ignored)
    else $error("unmapped write changed a register");

  property p_cmp_isolated;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (wr_en && hit_ladder) |=> $stable(comparator_mode_field_out);
  endproperty
  a_cmp_isolated: assert property (p_cmp_isolated)
    else $error("ladder write disturbed comparator mode");

  property p_sleep_keep;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (sleep_in && !(wr_en && hit_ladder)) |=>
      $stable({ladder_power_enable_out, ladder_pin_output_enable_out,
        ladder_range_select_out, ladder_source_select_out,
        ladder_tap_code_out});
  endproperty
  a_sleep_keep: assert property (p_sleep_keep)
    else $error("ladder outputs moved during sleep");

  property p_status_readback;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (psel_in && !penable_in && !pwrite_in && hit_stat) |=>
      prdata_out[1:0] == $past({sleep_in, shared_analog_pin_connect_out});
  endproperty
  a_status_readback: assert property (p_status_readback)
    else $error("status readback wrong");

  c_pin_on: cover property (@(posedge ref_clk_in)
    shared_analog_pin_connect_out);
  c_range_hi: cover property (@(posedge ref_clk_in)
    ladder_power_enable_out && ladder_range_select_out);
  c_tap_max: cover property (@(posedge ref_clk_in)
    ladder_tap_code_out == 4'hF);
  c_bad_addr: cover property (@(posedge ref_clk_in) pslverr_out);
  c_ext_src: cover property (@(posedge ref_clk_in)
    ladder_power_enable_out && ladder_source_select_out);
endmodule : crlc_top

// file: crlc_tb.sv
// Self-checking bench for the ladder control register bank
`timescale 1ns/1ps
module testbench;
  logic ref_clk_in = 0, rstn_in = 0, psel = 0, pen = 0, pwr = 0, slp = 0;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, seed = 32'hB9D8D85B;
  logic [3:0] pst = 0, tap;
  logic [1:0] res = 0;
  logic prdy, perr, pwe, poe, rng, src, conn;
  logic [2:0] mode;
  logic [7:0] dir, m_lad, m_dir;
  logic [5:0] m_cmp;
  int num_errors = 0, n_compared = 0, cyc = 0;

  crlc_top i_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
    .pwdata_in(pwd), .pstrb_in(pst), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .comparator_result_in(res), .sleep_in(slp),
    .ladder_power_enable_out(pwe), .ladder_pin_output_enable_out(poe),
    .ladder_range_select_out(rng), .ladder_source_select_out(src),
    .ladder_tap_code_out(tap), .shared_analog_pin_connect_out(conn),
    .comparator_mode_field_out(mode), .port_f_direction_out(dir));

  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [31:0] exp_rd(input logic [11:0] a);
    case (a)
      12'h000: return {24'h0, m_lad};
      12'h004: return {24'h0, res, m_cmp};
      12'h008: return {24'h0, m_dir};
      12'h00C: return {30'h0, slp, m_lad[6] & m_dir[5]};
      default: return 32'h0;
    endcase
  endfunction : exp_rd

  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic chk_out();
    chk({24'h0, pwe, poe, rng, src, tap}, {24'h0, m_lad});
    chk(32'(conn), 32'(m_lad[6] & m_dir[5]));
    chk(32'(mode), 32'(m_cmp[2:0]));
    chk(32'(dir), 32'(m_dir));
  endtask : chk_out

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    pst <= s;
    @(posedge ref_clk_in);
    pen <= 1;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    chk(32'(n < 50), 32'h1);
    chk(32'(perr), 32'(a >= 12'h010));
    if (!w) begin
      chk(prd, exp_rd(a));
    end else if (s[0]) begin
      case (a)
        12'h000: m_lad = d[7:0];
        12'h004: m_cmp = d[5:0];
        12'h008: m_dir = d[7:0];
        default: ;
      endcase
    end
    psel <= 0;
    pen <= 0;
    @(posedge ref_clk_in);
    chk_out();
  endtask : apb

  task automatic rst_seq();
    rstn_in <= 0;
    repeat (6) @(posedge ref_clk_in);
    rstn_in <= 1;
    m_lad = 8'h00;
    m_cmp = 6'h00;
    m_dir = 8'hFF;
    repeat (6) @(posedge ref_clk_in);
    chk_out();
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 12'(k * 4), 32'h0, 4'h0);
    end
  endtask : rst_seq

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    logic [31:0] r;
    logic [31:0] d;
    logic [11:0] a;
    rst_seq();
    for (int i = 0; i < 400; i++) begin
      if (i == 200) begin
        rst_seq();
      end
      r = xs();
      d = xs();
      if (r[28] & r[27]) begin
        a = {2'b01, r[9:2], 2'b00};
      end else begin
        a = {8'h0, r[3:2], 2'b00};
      end
      // Software powers the ladder down before sleep
      if (r[29] && m_lad[7]) begin
        apb(1'b1, 12'h000, {24'h0, 1'b0, m_lad[6:0]}, 4'h1);
      end
      // Sleep level toggles must not disturb register contents
      res <= r[31:30];
      slp <= r[29];
      repeat (6) @(posedge ref_clk_in);
      if (r[19] && a == 12'h000) begin
        if (r[29]) begin
          d[7] = 1'b0;
        end
        // Direction bit set before the pin is routed
        if (d[6] && !m_dir[5]) begin
          apb(1'b1, 12'h008, {24'h0, m_dir | 8'h20}, 4'h1);
        end
        // Converter reference setup lies outside this block
      end
      apb(r[19], a, d, {r[24:22], r[21] | r[20]});
    end
    tally_and_finish();
  end
endmodule : testbench
